// *** hw/qdc_pkg.sv ***
// Constants and carrier types for the four-channel DAC serial controller.
// Assumes a single system clock domain; serial pins are sampled by it.
package qdc_pkg;
  localparam int QDC_WORD_W = 16;
  localparam int QDC_DATA_W = 12;
  localparam int QDC_CHANNELS = 4;
  localparam int QDC_CMD_HI = 15;
  localparam int QDC_CMD_LO = 12;
  localparam logic [4:0] QDC_BIT_CNT_FULL = 5'h10;
  // Address/control codes {addr hi, addr lo, cmd hi, cmd lo}
  localparam logic [1:0] QDC_CTL_LOAD_IN = 2'h1;
  localparam logic [1:0] QDC_CTL_LOAD_UPD = 2'h3;
  localparam logic [3:0] QDC_CODE_NOP = 4'h0;
  localparam logic [3:0] QDC_CODE_UPDATE = 4'h4;
  localparam logic [3:0] QDC_CODE_LOAD_ALL = 4'h8;
  localparam logic [3:0] QDC_CODE_SHUTDOWN = 4'hC;
  localparam logic [3:0] QDC_CODE_UPO_LOW = 4'h2;
  localparam logic [3:0] QDC_CODE_UPO_HIGH = 4'h6;
  localparam logic [3:0] QDC_CODE_MODE_RISE = 4'hE;
  localparam logic [3:0] QDC_CODE_MODE_FALL = 4'hA;
  // Settling time after power-up or wake, for the controlling logic
  localparam int QDC_SETTLE_NS = 15000;
  localparam int QDC_CLK_NS = 4;
  localparam int QDC_SETTLE_CYC = QDC_SETTLE_NS / QDC_CLK_NS;

  typedef logic [QDC_DATA_W-1:0] qdc_code_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
  } qdc_pins_t;
endpackage : qdc_pkg

// *** hw/qdc_core.sv ***
// Serial command and register logic of a four-channel 12-bit DAC.
// Assumes the serial master runs its clock well below CLK/4.
// Function
// R1: Clear input low zeroes all registers, user output and serial output.
// R2: Lockout input low makes the shutdown command ignored.
// R3: One 16-bit shift register receives words and echoes them out.
// R4: Each of four channels has an input register and a DAC register.
// R5: Code 1100 enters shutdown only while lockout input is high.
// R6: In shutdown, serial interface works and input registers are kept.
// R7: Shutdown ends by copying inputs to DACs or loading new data.
// R8: Master waits 15 us before trusting outputs after wake.
// R9: Word is address, control, then 12 data bits, MSB first.
// R10: Shift register contents appear on the serial output.
// R11: Commands load inputs, load DACs directly, or copy all inputs.
// R12: Power-up state equals the cleared state, falling-edge mode.
// R13: Chip select low samples data on serial clock rising edges.
// R14: Word is decoded and applied when chip select returns high.
// R15: Control 01 loads input, 11 also updates DACs, 1000 loads all.
// R16: Data-free codes: update, shutdown, user output, edge mode, nop.
`timescale 1ns/100ps
`default_nettype none
module qdc_core
  import qdc_pkg::*;
#(
  parameter int CHANNELS = QDC_CHANNELS
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic CLEAR_N,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic DIN,
  input wire logic SHUTDOWN_LOCKOUT_N,
  output logic DOUT,
  output logic USER_LOGIC_OUTPUT,
  output logic SHUTDOWN,
  output logic MODE_RISE,
  output qdc_code_t [CHANNELS-1:0] DAC_CODE,
  output qdc_code_t [CHANNELS-1:0] INPUT_CODE
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    qdc_pins_t s1;
    qdc_pins_t s2;
    logic lock1;
    logic lock2;
    logic clr1;
    logic clr2;
    logic sclk_d;
    logic cs_d;
    // R3 shared in/out shift register
    logic [QDC_WORD_W-1:0] shift;
    logic [4:0] bits;
    logic dout;
    logic user_logic_output;
    logic shdn;
    logic mode_rise;
    // R4 two-stage channel buffer
    qdc_code_t [CHANNELS-1:0] inreg;
    qdc_code_t [CHANNELS-1:0] dacreg;
    qdc_code_t [CHANNELS-1:0] dac_out;
  } qdc_state_t;

  qdc_state_t st;
  qdc_state_t next_st;

  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic [3:0] code;
  logic [1:0] addr;
  qdc_code_t data;

  assign sclk_rise = st.s2.sclk & ~st.sclk_d & ~st.s2.cs_n;
  assign sclk_fall = ~st.s2.sclk & st.sclk_d & ~st.s2.cs_n;
  assign cs_rise = st.s2.cs_n & ~st.cs_d;
  // R9 word fields
  assign code = st.shift[QDC_CMD_HI:QDC_CMD_LO];
  assign addr = code[3:2];
  assign data = st.shift[QDC_DATA_W-1:0];

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.s1 = '{cs_n: CS_N, sclk: SCLK, din: DIN};
    next_st.s2 = st.s1;
    next_st.lock1 = SHUTDOWN_LOCKOUT_N;
    next_st.lock2 = st.lock1;
    next_st.clr1 = CLEAR_N;
    next_st.clr2 = st.clr1;
    next_st.sclk_d = st.s2.sclk;
    next_st.cs_d = st.s2.cs_n;
    // R13 sample on rising edge
    if (sclk_rise) begin
      next_st.shift = {st.shift[QDC_WORD_W-2:0], st.s2.din};
      if (st.bits != QDC_BIT_CNT_FULL) begin
        next_st.bits = st.bits + 5'h1;
      end
    end
    // R10 echo out per edge mode
    if (st.mode_rise ? sclk_rise : sclk_fall) begin
      next_st.dout = st.shift[QDC_WORD_W-1];
    end
    if (~st.s2.cs_n && st.cs_d) begin
      next_st.bits = 5'h0;
    end
    // R14 decode on chip select rise
    if (cs_rise && st.bits == QDC_BIT_CNT_FULL) begin
      // R15 load commands
      if (code[1:0] == QDC_CTL_LOAD_IN) begin
        next_st.inreg[addr] = data;
      end else if (code[1:0] == QDC_CTL_LOAD_UPD) begin
        // R11 load and update all DACs
        next_st.inreg[addr] = data;
        next_st.dacreg = next_st.inreg;
        next_st.shdn = 1'b0;
      end else if (code == QDC_CODE_LOAD_ALL) begin
        for (int i = 0; i < CHANNELS; i++) begin
          next_st.inreg[i] = data;
          next_st.dacreg[i] = data;
        end
        // R7 wake with new data
        next_st.shdn = 1'b0;
      end else if (code == QDC_CODE_UPDATE) begin
        // R7 wake by recall
        next_st.dacreg = st.inreg;
        next_st.shdn = 1'b0;
      end else if (code == QDC_CODE_SHUTDOWN) begin
        // R5 shutdown gated by lockout
        if (st.lock2) begin
          next_st.shdn = 1'b1;
        end
      end else if (code == QDC_CODE_UPO_LOW) begin
        next_st.user_logic_output = 1'b0;
      end else if (code == QDC_CODE_UPO_HIGH) begin
        next_st.user_logic_output = 1'b1;
      end else if (code == QDC_CODE_MODE_RISE) begin
        // R16 edge mode and update
        next_st.mode_rise = 1'b1;
        next_st.dacreg = st.inreg;
        next_st.shdn = 1'b0;
      end else if (code == QDC_CODE_MODE_FALL) begin
        next_st.mode_rise = 1'b0;
        next_st.dacreg = st.inreg;
        next_st.shdn = 1'b0;
      end
    end
    // R2 lockout low wakes, keeps outputs
    if (!st.lock2) begin
      next_st.shdn = 1'b0;
    end
    // R1 clear zeroes all but the pin synchronizers and edge detectors
    if (!st.clr2) begin
      next_st.shift = '0;
      next_st.bits = 5'h0;
      next_st.dout = 1'b0;
      next_st.user_logic_output = 1'b0;
      next_st.shdn = 1'b0;
      next_st.mode_rise = 1'b0;
      next_st.inreg = '0;
      next_st.dacreg = '0;
    end
    // R6 blank codes in shutdown
    next_st.dac_out = next_st.shdn ? '0 : next_st.dacreg;
  end

  // R12 reset equals cleared state
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st <= '0;
    end else if (CE) begin
      st <= next_st;
    end
  end

  // R6 registered blanked codes
  assign DAC_CODE = st.dac_out;
  assign INPUT_CODE = st.inreg;
  assign DOUT = st.dout;
  assign USER_LOGIC_OUTPUT = st.user_logic_output;
  assign SHUTDOWN = st.shdn;
  assign MODE_RISE = st.mode_rise;

  // ****************************************
  // Checks
  // ****************************************
  // R1 clear zeroes
  clear_zero_a: assert property (@(posedge CLK) disable iff (RST) // R1
    (CE && !st.clr2) |=> (st.dout == 1'b0 && st.user_logic_output == 1'b0 &&
    st.inreg == '0 && st.dacreg == '0))
    else $error("clear did not zero state");
  // R2 lockout blocks shutdown
  lockout_block_a: assert property (@(posedge CLK) disable iff (RST) // R2
    (CE && !st.lock2) |=> !st.shdn)
    else $error("shutdown while locked out");
  // R5 shutdown command
  shdn_enter_a: assert property (@(posedge CLK) disable iff (RST) // R5
    (CE && cs_rise && st.bits == QDC_BIT_CNT_FULL &&
    code == QDC_CODE_SHUTDOWN && st.lock2 && st.clr2) |=> st.shdn)
    else $error("shutdown command not taken");
  // R6 inputs kept in shutdown
  shdn_keep_a: assert property (@(posedge CLK) disable iff (RST) // R6
    (st.shdn && !cs_rise && st.clr2) |=> $stable(st.inreg))
    else $error("input register changed without command");
  // R13 shift on rising edge
  shift_rise_a: assert property (@(posedge CLK) disable iff (RST) // R13
    (CE && sclk_rise && st.clr2) |=>
    st.shift[0] == $past(st.s2.din))
    else $error("serial bit not sampled");
  // R15 input load
  load_in_a: assert property (@(posedge CLK) disable iff (RST) // R15
    (CE && cs_rise && st.bits == QDC_BIT_CNT_FULL && st.clr2 &&
    code[1:0] == QDC_CTL_LOAD_IN) |=> st.inreg[$past(addr)] == $past(data))
    else $error("input register not loaded");
  // R11 update copies inputs
  update_all_a: assert property (@(posedge CLK) disable iff (RST) // R11
    (CE && cs_rise && st.bits == QDC_BIT_CNT_FULL && st.clr2 &&
    code == QDC_CODE_UPDATE) |=> st.dacreg == $past(st.inreg))
    else $error("DAC registers not updated");
  // R10 echo of shift MSB
  echo_out_a: assert property (@(posedge CLK) disable iff (RST) // R10
    (CE && st.clr2 && !st.mode_rise && sclk_fall) |=>
    st.dout == $past(st.shift[QDC_WORD_W-1]))
    else $error("serial echo wrong");
endmodule : qdc_core
`default_nettype wire

// *** tb/qdc_master.sv ***
// Serial master model for the DAC controller: chip select, clock, data.
// Assumes the controller samples these pins with a much faster clock.
`timescale 1ns/100ps
`default_nettype none
module qdc_master (
  output var logic cs_n,
  output var logic sclk,
  output var logic din
);
  // ****************
  // Frame generation
  // ****************
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end

  task send(input logic [15:0] w, input int n);
    int i;
    #1 cs_n = 1'b0;
    #50;
    for (i = 15; i > 15 - n; i--) begin
      din = w[i];
      #62.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
    end
    #50 cs_n = 1'b1;
    // Released data line must not keep its last value
    din = ~din;
    // Keep chip select high between frames
    #100;
  endtask : send
endmodule : qdc_master
`default_nettype wire

// *** tb/test_quad_dac_serial_control.sv ***
// Self-checking bench for the DAC serial controller.
// Assumes qdc_pkg and qdc_core are compiled, serial clock 125 ns.
`timescale 1ns/100ps
`default_nettype none
module test_quad_dac_serial_control;
  import qdc_pkg::*;
  logic clk, rst, ce, clear_n, lock_n, cs_n, sclk, din;
  logic dout, user_logic_output, sd, mrise, eu, es, em, eo;
  logic [15:0] sh;
  qdc_code_t [QDC_CHANNELS-1:0] dac, inp, ei, ed;
  int error_cnt, total_checks, i;
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  error_cnt++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end

  qdc_core qdc_core_inst (.CLK(clk), .RST(rst), .CE(ce),
    .CLEAR_N(clear_n), .CS_N(cs_n), .SCLK(sclk), .DIN(din),
    .SHUTDOWN_LOCKOUT_N(lock_n), .DOUT(dout), .USER_LOGIC_OUTPUT(user_logic_output),
    .SHUTDOWN(sd), .MODE_RISE(mrise), .DAC_CODE(dac), .INPUT_CODE(inp));
  qdc_master qdc_master_inst (.cs_n(cs_n), .sclk(sclk), .din(din));

  // *************
  // Bench helpers
  // *************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  task check_all;
    `CHK(inp, ei)
    `CHK(dac, es ? '0 : ed)
    `CHK({user_logic_output, sd, mrise, dout}, {eu, es, em, eo})
  endtask : check_all

  task xfer(input logic [15:0] w, input int n);
    qdc_master_inst.send(w, n);
    // Echo bit follows the edge mode in force during the frame
    for (int k = 15; k > 15 - n; k--) begin
      if (em) eo = sh[15];
      sh = {sh[14:0], w[k]};
      if (!em) eo = sh[15];
    end
    if (n == 16) begin
      if (w[13:12] == QDC_CTL_LOAD_IN) ei[w[15:14]] = w[11:0];
      else if (w[13:12] == QDC_CTL_LOAD_UPD) begin
        ei[w[15:14]] = w[11:0];
        ed = ei;
        es = 1'b0;
      end else case (w[15:12])
        QDC_CODE_LOAD_ALL: ei = {4{w[11:0]}};
        QDC_CODE_SHUTDOWN: es = lock_n;
        QDC_CODE_UPO_LOW: eu = 1'b0;
        QDC_CODE_UPO_HIGH: eu = 1'b1;
        QDC_CODE_MODE_RISE: em = 1'b1;
        QDC_CODE_MODE_FALL: em = 1'b0;
        default: ;
      endcase
      if (w[13:12] == 2'h0 && w[15:14] != 2'h0 && w[15:14] != 2'h3 ||
          w[15:12] == QDC_CODE_MODE_RISE || w[15:12] == QDC_CODE_MODE_FALL)
        begin
        ed = ei;
        es = 1'b0;
      end
    end
    repeat (8) @(posedge clk);
    check_all();
  endtask : xfer

  // **************
  // Test sequence
  // **************
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    clear_n = 1'b1;
    lock_n = 1'b1;
    {ei, ed, eu, es, em, eo, sh} = '0;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    repeat (6) @(posedge clk);
    check_all();
    for (i = 0; i < 4; i++) xfer({i[1:0], 2'h1, 12'hA5C ^ 12'(i)}, 16);
    xfer(16'h4000, 16);
    xfer(16'h7FFF, 16);
    xfer(16'h8123, 16);
    xfer(16'h0ABC, 16);
    xfer(16'h1BCD, 8);
    $display("test loads done");
    xfer(16'h6000, 16);
    xfer(16'h2000, 16);
    xfer(16'h1BCD, 16);
    xfer(16'hE001, 16);
    xfer(16'h2345, 16);
    xfer(16'hA000, 16);
    $display("test codes done");
    @(posedge clk);
    #1 lock_n = 1'b0;
    xfer(16'hC000, 16);
    @(posedge clk);
    #1 lock_n = 1'b1;
    xfer(16'hC000, 16);
    xfer(16'h5321, 16);
    xfer(16'h4000, 16);
    repeat (QDC_SETTLE_CYC) @(posedge clk);
    xfer(16'hC000, 16);
    xfer(16'h8777, 16);
    $display("test shutdown done");
    #1 ce = 1'b0;
    qdc_master_inst.send(16'h3FFF, 16);
    repeat (8) @(posedge clk);
    check_all();
    #1 ce = 1'b1;
    xfer(16'h6000, 16);
    xfer(16'hE000, 16);
    $display("test freeze done");
    @(posedge clk);
    #1 clear_n = 1'b0;
    {ei, ed, eu, es, em, eo, sh} = '0;
    repeat (8) @(posedge clk);
    check_all();
    #1 clear_n = 1'b1;
    $display("test clear done");
    give_verdict();
  end

  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
endmodule : test_quad_dac_serial_control
`default_nettype wire
